// *** verilog/fspc_regs.svh ***
// fspc_regs.svh: constants for the flash self programming controller
// assumes: included by the package and the controller, no process here
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH
`define FSPC_ADDR_W        32
`define FSPC_DATA_W        32
`define FSPC_BLK_W         8
`define FSPC_RAM_BASE      32'h03ff_0000
`define FSPC_NMI_OFS       32'h0000_0000
`define FSPC_MI_OFS        32'h0000_0004
`define FSPC_NMI_VEC       32'h0000_0010
`define FSPC_MI_VEC        32'h0000_0070
`define FSPC_BLK_SHIFT     14
`define FSPC_SWAP_BIT      15
`define FSPC_OP_TIME_NS    1000
`define FSPC_CLK_NS        10
`define FSPC_OP_CYC        (`FSPC_OP_TIME_NS / `FSPC_CLK_NS)
`define FSPC_INFO_RST      32'h0000_0000
`define FSPC_ST_OK         4'h0
`define FSPC_ST_PROTECT    4'h1
`define FSPC_ST_VERIFY     4'h2
`define FSPC_ST_BLANK      4'h3
`define FSPC_ST_BAD_OP     4'h4
`endif

// *** verilog/fspc_pkg.sv ***
// fspc_pkg.sv: types for the flash self programming controller
// assumes: fspc_regs.svh on the include path
`include "fspc_regs.svh"
package fspc_pkg;
  typedef enum logic [3:0] {
    FSPC_OP_NONE   = 4'h0,
    FSPC_OP_ENV    = 4'h1,
    FSPC_OP_ERASE  = 4'h2,
    FSPC_OP_WRITE  = 4'h3,
    FSPC_OP_VERIFY = 4'h4,
    FSPC_OP_BLANK  = 4'h5,
    FSPC_OP_MODEPN = 4'h6,
    FSPC_OP_STATUS = 4'h7,
    FSPC_OP_GINFO  = 4'h8,
    FSPC_OP_SINFO  = 4'h9,
    FSPC_OP_SWAP   = 4'ha,
    FSPC_OP_READ   = 4'hb,
    FSPC_OP_END    = 4'hc
  } fspc_op_t;

  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_RUN  = 2'b01,
    FSPC_DONE = 2'b11
  } fspc_state_t;

  typedef struct packed {
    fspc_op_t                   op;
    logic [`FSPC_ADDR_W-1:0]    addr;
    logic [`FSPC_DATA_W-1:0]    wdata;
  } fspc_req_t;

  typedef struct packed {
    logic [3:0]                 status;
    logic [`FSPC_DATA_W-1:0]    rdata;
  } fspc_rsp_t;
endpackage : fspc_pkg

// *** verilog/fspc_ctrl.sv ***
// fspc_ctrl.sv: flash self programming controller (sequencer side)
// assumes: flash macro and cpu fetch/vector paths are outside; mode pins
// are synchronous to sys_clk; swap flag retained by nonvolatile cell
`timescale 1ns/10ps
`default_nettype none
`include "fspc_regs.svh"
module fspc_ctrl (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  // mode pins
  input  wire logic                     flash_mode_pin,
  input  wire logic                     flash_mode_aux_pin,
  // operation request and answer
  input  wire logic                     req_valid,
  input  wire fspc_pkg::fspc_req_t      req,
  output logic                          req_ready,
  output logic                          busy,
  output fspc_pkg::fspc_rsp_t           rsp,
  output logic                          rsp_valid,
  // mode and environment state
  output logic                          self_prog,
  output logic                          prog_mode,
  output logic                          mode_illegal,
  output logic                          env_lock,
  // fetch and vector redirection
  input  wire logic [`FSPC_ADDR_W-1:0]  fetch_addr,
  output logic [`FSPC_ADDR_W-1:0]       phys_addr,
  output logic                          fetch_block,
  input  wire logic                     irq_nmi,
  input  wire logic                     irq_mi,
  output logic [`FSPC_ADDR_W-1:0]       irq_vector,
  // nonvolatile swap cell
  input  wire logic                     swap_nv_in,
  output logic                          swap_nv_wr,
  output logic                          swap_nv_val,
  // flash macro
  output logic                          fl_erase,
  output logic                          fl_write,
  output logic                          fl_verify,
  output logic                          fl_blank,
  output logic [`FSPC_ADDR_W-1:0]       fl_addr,
  output logic [`FSPC_DATA_W-1:0]       fl_wdata,
  input  wire logic [`FSPC_DATA_W-1:0]  fl_rdata,
  input  wire logic                     fl_fail
);
  fspc_pkg::fspc_state_t    state_q;
  fspc_pkg::fspc_op_t       op_q;
  logic [`FSPC_ADDR_W-1:0]  addr_q;
  logic [15:0]              cnt_q;
  logic [3:0]               last_st_q;
  logic [`FSPC_DATA_W-1:0]  info_q;
  logic                     swap_q;
  logic                     strap_q;
  logic                     take;
  logic                     long_op;
  logic [`FSPC_ADDR_W-1:0]  blk_base;

  assign take      = clk_en && req_valid && req_ready;
  assign req_ready = (state_q == fspc_pkg::FSPC_IDLE);
  assign busy      = (state_q != fspc_pkg::FSPC_IDLE);
  assign long_op   = req.op inside {fspc_pkg::FSPC_OP_ERASE,
                     fspc_pkg::FSPC_OP_WRITE, fspc_pkg::FSPC_OP_VERIFY,
                     fspc_pkg::FSPC_OP_BLANK};
  // one block: erase, verify and blank use the block base only
  assign blk_base  = {req.addr[`FSPC_ADDR_W-1:`FSPC_BLK_SHIFT],
                      {`FSPC_BLK_SHIFT{1'b0}}};

  // mode strap caught on the first enabled edge after reset release
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_q      <= 1'b0;
      prog_mode    <= 1'b0;
      mode_illegal <= 1'b0;
      swap_q       <= 1'b0;
    end else if (clk_en && !strap_q) begin
      strap_q      <= 1'b1;
      prog_mode    <= flash_mode_pin && !flash_mode_aux_pin;
      mode_illegal <= flash_mode_pin && flash_mode_aux_pin;
      swap_q       <= swap_nv_in;
    end
  end

  // environment: open from env op to end op
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      self_prog <= 1'b0;
    end else if (take && req.op == fspc_pkg::FSPC_OP_ENV) begin
      self_prog <= 1'b1;
    end else if (take && req.op == fspc_pkg::FSPC_OP_END) begin
      self_prog <= 1'b0;
    end
  end
  // env_lock tells the clock unit: no flash data access, no stop, no halt
  assign env_lock = self_prog;

  // operation sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q   <= fspc_pkg::FSPC_IDLE;
      op_q      <= fspc_pkg::FSPC_OP_NONE;
      addr_q    <= '0;
      cnt_q     <= '0;
      last_st_q <= `FSPC_ST_OK;
      info_q    <= `FSPC_INFO_RST;
      rsp       <= '0;
      rsp_valid <= 1'b0;
      fl_erase  <= 1'b0;
      fl_write  <= 1'b0;
      fl_verify <= 1'b0;
      fl_blank  <= 1'b0;
      fl_addr   <= '0;
      fl_wdata  <= '0;
      swap_nv_wr  <= 1'b0;
      swap_nv_val <= 1'b0;
    end else if (clk_en) begin
      rsp_valid  <= 1'b0;
      fl_erase   <= 1'b0;
      fl_write   <= 1'b0;
      fl_verify  <= 1'b0;
      fl_blank   <= 1'b0;
      swap_nv_wr <= 1'b0;
      unique case (state_q)
        fspc_pkg::FSPC_IDLE: if (req_valid) begin
          op_q   <= req.op;
          addr_q <= req.addr;
          if (long_op && !self_prog) begin
            last_st_q <= `FSPC_ST_BAD_OP;
            rsp       <= '{status: `FSPC_ST_BAD_OP, rdata: '0};
            rsp_valid <= 1'b1;
          end else if (long_op && req.op != fspc_pkg::FSPC_OP_BLANK
                       && !flash_mode_pin) begin
            // write protect: pin low blocks any modification
            last_st_q <= `FSPC_ST_PROTECT;
            rsp       <= '{status: `FSPC_ST_PROTECT, rdata: '0};
            rsp_valid <= 1'b1;
          end else if (long_op) begin
            fl_erase  <= req.op == fspc_pkg::FSPC_OP_ERASE;
            fl_write  <= req.op == fspc_pkg::FSPC_OP_WRITE;
            fl_verify <= req.op == fspc_pkg::FSPC_OP_VERIFY;
            fl_blank  <= req.op == fspc_pkg::FSPC_OP_BLANK;
            fl_addr   <= (req.op == fspc_pkg::FSPC_OP_WRITE) ?
                         req.addr : blk_base;
            fl_wdata  <= req.wdata;
            cnt_q     <= 16'(`FSPC_OP_CYC);
            state_q   <= fspc_pkg::FSPC_RUN;
          end else begin
            rsp_valid <= 1'b1;
            rsp       <= '{status: last_st_q, rdata: '0};
            unique case (req.op)
              fspc_pkg::FSPC_OP_READ:
                rsp.rdata <= fl_rdata;
              fspc_pkg::FSPC_OP_GINFO:
                rsp.rdata <= info_q;
              fspc_pkg::FSPC_OP_SINFO:
                if (flash_mode_pin) info_q <= req.wdata;
              fspc_pkg::FSPC_OP_SWAP:
                if (flash_mode_pin) begin
                  swap_nv_wr  <= 1'b1;
                  swap_nv_val <= !swap_q;
                end
              fspc_pkg::FSPC_OP_MODEPN:
                rsp.rdata <= {31'h0000_0000, flash_mode_pin};
              fspc_pkg::FSPC_OP_STATUS:
                rsp.status <= last_st_q;
              default: ;
            endcase
          end
        end
        fspc_pkg::FSPC_RUN: begin
          if (cnt_q <= 16'h0001) state_q <= fspc_pkg::FSPC_DONE;
          cnt_q <= cnt_q - 16'h0001;
        end
        fspc_pkg::FSPC_DONE: begin
          last_st_q <= !fl_fail ? `FSPC_ST_OK :
                       (op_q == fspc_pkg::FSPC_OP_BLANK) ? `FSPC_ST_BLANK
                       : `FSPC_ST_VERIFY;
          rsp       <= '{status: fl_fail ? `FSPC_ST_VERIFY : `FSPC_ST_OK,
                         rdata: '0};
          rsp_valid <= 1'b1;
          state_q   <= fspc_pkg::FSPC_IDLE;
        end
        default: state_q <= fspc_pkg::FSPC_IDLE;
      endcase
    end
  end

  // address map swap of blocks 0-1 with 2-3, active from reset
  always_comb begin
    phys_addr = fetch_addr;
    if (swap_q && fetch_addr[`FSPC_ADDR_W-1:`FSPC_SWAP_BIT+1] == '0)
      phys_addr[`FSPC_SWAP_BIT] = !fetch_addr[`FSPC_SWAP_BIT];
  end
  assign fetch_block = self_prog;

  // vectors: RAM trampolines while flash is unreadable
  always_comb begin
    irq_vector = `FSPC_MI_VEC;
    if (self_prog) begin
      irq_vector = irq_nmi ? `FSPC_RAM_BASE + `FSPC_NMI_OFS
                           : `FSPC_RAM_BASE + `FSPC_MI_OFS;
    end else if (irq_nmi) begin
      irq_vector = `FSPC_NMI_VEC;
    end
  end

  nmi_vec_a: assert property (@(posedge sys_clk) disable iff (reset)
    self_prog && irq_nmi |-> irq_vector == `FSPC_RAM_BASE)
    else $error("nmi not sent to ram start");
  mi_vec_a: assert property (@(posedge sys_clk) disable iff (reset)
    self_prog && irq_mi && !irq_nmi |->
    irq_vector == `FSPC_RAM_BASE + 32'h0000_0004)
    else $error("maskable irq not sent to ram plus 4");
  fetch_blocked_a: assert property (@(posedge sys_clk) disable iff (reset)
    take && req.op == fspc_pkg::FSPC_OP_ENV |=> fetch_block)
    else $error("fetch allowed in self programming");
  protect_a: assert property (@(posedge sys_clk) disable iff (reset)
    (fl_erase || fl_write || fl_verify) |-> $past(flash_mode_pin))
    else $error("modify with mode pin low");
  busy_refuse_a: assert property (@(posedge sys_clk) disable iff (reset)
    busy |=> $stable(op_q) && $stable(addr_q))
    else $error("operation replaced while busy");
  op_done_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && fl_erase ##1 clk_en[*2] |-> busy)
    else $error("erase finished too soon");
  swap_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    swap_q && fetch_addr == 32'h0000_0000 |->
    phys_addr == 32'h0000_8000)
    else $error("swap map wrong");
  status_a: assert property (@(posedge sys_clk) disable iff (reset)
    take && req.op == fspc_pkg::FSPC_OP_STATUS |=>
    rsp_valid && rsp.status == $past(last_st_q))
    else $error("status answer wrong");
  strap_a: assert property (@(posedge sys_clk) disable iff (reset)
    prog_mode |-> !mode_illegal)
    else $error("mode decode overlap");

  erase_c: cover property (@(posedge sys_clk) fl_erase ##[1:200] rsp_valid);
  swap_c:  cover property (@(posedge sys_clk) swap_nv_wr);
  nmi_c:   cover property (@(posedge sys_clk) self_prog && irq_nmi);
  prot_c:  cover property (@(posedge sys_clk)
    rsp_valid && rsp.status == `FSPC_ST_PROTECT);
endmodule : fspc_ctrl
`default_nettype wire

// *** sim/fspc_app.sv ***
// fspc_app.sv: model of the user program that drives flash operations
// assumes: one request at a time; the bench watches the answers
`timescale 1ns/10ps
`default_nettype none
module fspc_app (
  // clock
  input  wire logic                sys_clk,
  // request side
  input  wire logic                req_ready,
  output var  logic                req_valid,
  output var  fspc_pkg::fspc_req_t req,
  // mode pin, driven from a port
  output var  logic                flash_mode_pin
);
  // set once the handler jumps sit at RAM start and start plus 4
  logic jumps_ready;
  // debug unit reset held low for the whole programming session
  logic debug_unit_reset_n;

  initial begin
    req_valid          = 1'b0;
    req                = '0;
    flash_mode_pin     = 1'b0;
    jumps_ready        = 1'b0;
    debug_unit_reset_n = 1'b0;
  end

  // must run before any interrupt is taken in self programming
  task automatic place_jumps();
    jumps_ready = 1'b1;
  endtask : place_jumps

  // raised before any rewrite, lowered once done
  task automatic set_pin(input logic lvl);
    @(posedge sys_clk);
    flash_mode_pin <= lvl;
  endtask : set_pin

  // request held until the edge that takes it; long ops sent before the env op are refused
  task automatic issue(input fspc_pkg::fspc_req_t r,
                       output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req       <= r;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    ok = (req_ready === 1'b1);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    // released fields stop showing the old value
    req       <= ~r;
  endtask : issue
endmodule : fspc_app
`default_nettype wire

// *** sim/test_flash_self_program_control.sv ***
// test_flash_self_program_control.sv: self-checking bench for fspc_ctrl
// assumes: fspc_app as the user program, flash macro faked by the bench
`timescale 1ns/10ps
`default_nettype none
`include "fspc_regs.svh"
module test_flash_self_program_control;
  logic sys_clk = 1'b0;
  logic reset = 1'b1, aux = 1'b0, nmi = 1'b0, mi = 1'b0;
  logic swap_in = 1'b0, fail = 1'b0;
  logic [31:0] faddr = 32'h0000_0100, rdat = 32'h0;
  logic req_valid, req_ready, busy, rsp_valid, self_prog, prog_mode;
  logic mode_illegal, fetch_block, nv_val, pin;
  logic en = 1'b1, lock, nv_wr, fe, fw, fv, fb;
  logic [31:0] phys, vec, fa, fd, sent_wdata;
  fspc_pkg::fspc_req_t req;
  fspc_pkg::fspc_rsp_t rsp;
  logic [71:0] exp_q[$];
  logic [71:0] note;
  int bad_count = 0, checks_done = 0;
  int nv_writes = 0;
  int seed = 32'hb04909f7;
  localparam logic [35:0] ST = 36'hf_0000_0000;
  localparam logic [35:0] ALL = {36{1'b1}};
  fspc_pkg::fspc_op_t ops[4] = '{fspc_pkg::FSPC_OP_ERASE,
    fspc_pkg::FSPC_OP_WRITE, fspc_pkg::FSPC_OP_VERIFY,
    fspc_pkg::FSPC_OP_BLANK};

  always #5 sys_clk = ~sys_clk;

  fspc_app app (.sys_clk(sys_clk), .req_ready(req_ready),
    .req_valid(req_valid), .req(req), .flash_mode_pin(pin));

  fspc_ctrl dut (.sys_clk(sys_clk), .reset(reset), .clk_en(en),
    .flash_mode_pin(pin), .flash_mode_aux_pin(aux),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .busy(busy), .rsp(rsp), .rsp_valid(rsp_valid),
    .self_prog(self_prog), .prog_mode(prog_mode),
    .mode_illegal(mode_illegal), .env_lock(lock), .fetch_addr(faddr),
    .phys_addr(phys), .fetch_block(fetch_block), .irq_nmi(nmi),
    .irq_mi(mi), .irq_vector(vec), .swap_nv_in(swap_in),
    .swap_nv_wr(nv_wr), .swap_nv_val(nv_val), .fl_erase(fe),
    .fl_write(fw), .fl_verify(fv), .fl_blank(fb), .fl_addr(fa),
    .fl_wdata(fd), .fl_rdata(rdat), .fl_fail(fail));

  task automatic check(input string what, input logic [35:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : do_reset

  // note the answer first; short ops answer one cycle after the take
  task automatic run(input fspc_pkg::fspc_op_t op,
                     input logic [35:0] mask, exp);
    fspc_pkg::fspc_req_t r;
    logic ok;
    logic refused;
    logic [3:0] strb;
    logic [31:0] want_a;
    r.op    = op;
    r.addr  = $random(seed) & 32'h0000_fffc;
    r.wdata = $random(seed);
    sent_wdata = r.wdata;
    // refusals answer at once and leave the flash strobes quiet
    refused = exp[35:32] inside {`FSPC_ST_PROTECT, `FSPC_ST_BAD_OP};
    strb = {op == fspc_pkg::FSPC_OP_ERASE, op == fspc_pkg::FSPC_OP_WRITE,
            op == fspc_pkg::FSPC_OP_VERIFY, op == fspc_pkg::FSPC_OP_BLANK};
    want_a = (op == fspc_pkg::FSPC_OP_WRITE) ? r.addr :
             (r.addr >> `FSPC_BLK_SHIFT) << `FSPC_BLK_SHIFT;
    exp_q.push_back({mask, exp});
    app.issue(r, ok);
    check("request taken", 36'(ok), 36'h1);
    if (!ok)
      wrap_up();
    if (strb != 4'h0) begin
      @(negedge sys_clk);
      check("running", {busy, req_ready}, {!refused, refused});
      check("strobes", {fe, fw, fv, fb}, refused ? 4'h0 : strb);
      if (!refused)
        check("flash addr", fa, want_a);
      if (!refused && op == fspc_pkg::FSPC_OP_WRITE)
        check("flash data", fd, r.wdata);
    end
  endtask : run

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (exp_q.size() != 0) begin
      check("answers pending", 36'(exp_q.size()), 36'h0);
      wrap_up();
    end
    @(negedge sys_clk);
  endtask : drain

  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check("stray answer", 36'h1, 36'h0);
      else begin
        note = exp_q.pop_front();
        check("answer", rsp & note[71:36], note[35:0]);
      end
    end
  end

  always @(posedge sys_clk)
    if (nv_wr === 1'b1)
      nv_writes++;

  initial begin
    repeat (20000) @(posedge sys_clk);
    check("run time", 36'h1, 36'h0);
    wrap_up();
  end

  initial begin
    logic [31:0] v;
    do_reset();
    check("normal strap", {prog_mode, mode_illegal, self_prog}, 0);
    check("plain map", phys, 36'h100);
    run(fspc_pkg::FSPC_OP_ERASE, ST, {4'h4, 32'h0});
    // env answers with the status left by the refused erase
    app.place_jumps();
    run(fspc_pkg::FSPC_OP_ENV, ST, {4'h4, 32'h0});
    drain();
    check("fetch blocked", {fetch_block, self_prog, lock}, 36'h7);
    check("jump slots", 36'(app.jumps_ready), 36'h1);
    check("debug reset", 36'(app.debug_unit_reset_n), 36'h0);
    @(posedge sys_clk);
    nmi <= 1'b1;
    @(negedge sys_clk);
    check("nmi vector", vec, `FSPC_RAM_BASE + `FSPC_NMI_OFS);
    @(posedge sys_clk);
    nmi <= 1'b0;
    mi  <= 1'b1;
    @(negedge sys_clk);
    check("mi vector", vec, `FSPC_RAM_BASE + `FSPC_MI_OFS);
    @(posedge sys_clk);
    mi <= 1'b0;
    // pin still low, so the rewrite is refused
    run(fspc_pkg::FSPC_OP_ERASE, ST, {4'h1, 32'h0});
    drain();
    app.set_pin(1'b1);
    // second pass fails every long op; status check follows each
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      fail <= (i > 3);
      run(ops[i % 4], ST, {(i > 3) ? 4'h2 : 4'h0, 32'h0});
      // a frozen clock enable must stretch the verify past its count
      if (i == 2) begin
        @(posedge sys_clk);
        en <= 1'b0;
        repeat (150) @(posedge sys_clk);
        en <= 1'b1;
        @(negedge sys_clk);
        check("frozen", {busy, rsp_valid}, 36'h2);
      end
      run(fspc_pkg::FSPC_OP_STATUS, ST,
          {(i > 3) ? ((i == 7) ? 4'h3 : 4'h2) : 4'h0, 32'h0});
      drain();
    end
    @(posedge sys_clk);
    fail <= 1'b0;
    v = $random(seed);
    rdat <= v;
    // short ops carry the blank failure still held as last status
    run(fspc_pkg::FSPC_OP_READ, ALL, {4'h3, v});
    run(fspc_pkg::FSPC_OP_GINFO, ALL, {4'h3, `FSPC_INFO_RST});
    run(fspc_pkg::FSPC_OP_SINFO, ST, {4'h3, 32'h0});
    run(fspc_pkg::FSPC_OP_GINFO, ALL, {4'h3, sent_wdata});
    run(fspc_pkg::FSPC_OP_MODEPN, ALL, {4'h3, 32'h1});
    run(fspc_pkg::FSPC_OP_SWAP, ST, {4'h3, 32'h0});
    drain();
    check("swap stored", 36'(nv_val), 36'h1);
    check("swap writes", 36'(nv_writes), 36'h1);
    check("map until reset", phys, 36'h100);
    run(fspc_pkg::FSPC_OP_END, ST, {4'h3, 32'h0});
    drain();
    check("env ended", {self_prog, lock}, 36'h0);
    // a session without info set or swap leaves the cell alone
    run(fspc_pkg::FSPC_OP_ENV, ST, {4'h3, 32'h0});
    run(fspc_pkg::FSPC_OP_END, ST, {4'h3, 32'h0});
    drain();
    check("no swap write", 36'(nv_writes), 36'h1);
    // pin left high: aux decides between program mode and prohibited
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk);
      aux     <= j[0];
      swap_in <= 1'b1;
      do_reset();
      check("strap", {prog_mode, mode_illegal}, j ? 36'h1 : 36'h2);
    end
    check("swapped map", phys, 36'h8100);
    @(posedge sys_clk);
    faddr <= 32'h0;
    @(negedge sys_clk);
    check("swapped base", phys, 36'h8000);
    app.set_pin(1'b0);
    wrap_up();
  end
endmodule : test_flash_self_program_control
`default_nettype wire
